// >>> core/aspt_pkg.sv
// constants and helpers for the async serial parity transceiver
package aspt_pkg;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [2:0] OFF_MODE   = 3'h0; // async_mode_register
  localparam logic [2:0] OFF_STATUS = 3'h1; // async_error_status
  localparam logic [2:0] OFF_TXREG  = 3'h2; // transmit_shift_register
  localparam logic [2:0] OFF_RXBUF  = 3'h3; // receive_buffer
  localparam logic [2:0] OFF_BAUD   = 3'h4; // baud_generator_control
  // ----------------------------------------------------------------
  // mode register fields
  // ----------------------------------------------------------------
  localparam int MODE_TX_EN = 7; // transmit enable
  localparam int MODE_RX_EN = 6; // receive enable
  localparam int MODE_PS1  = 5; // parity select high
  localparam int MODE_PS0  = 4; // parity select low
  localparam int MODE_CL   = 3; // 1: eight character bits
  localparam int MODE_SL   = 2; // 1: two stop bits
  localparam int MODE_ESUP = 1; // done irq suppress on error frames
  localparam int MODE_SCK  = 0; // 1: internal baud clock
  // ----------------------------------------------------------------
  // status fields and reset values
  // ----------------------------------------------------------------
  localparam int ST_OVR = 0; // overrun_flag
  localparam int ST_FE  = 1; // framing error
  localparam int ST_PE  = 2; // parity error
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] BAUD_RST = 8'h00;
  // parity modes as printed in the mode register
  typedef enum logic [1:0] {
    PAR_NONE = 2'h0,
    PAR_ZERO = 2'h1,
    PAR_ODD  = 2'h2,
    PAR_EVEN = 2'h3
  } aspt_par_t;
  // parity bit for a character of 7 or 8 bits
  function automatic logic par_bit(input logic [7:0] d,
                                   input logic       len8,
                                   input aspt_par_t  pm);
    logic ones;
    ones = ^(len8 ? d : {1'b0, d[6:0]});
    case (pm)
      PAR_EVEN: par_bit = ones;
      PAR_ODD:  par_bit = ~ones;
      default:  par_bit = 1'b0;
    endcase
  endfunction : par_bit
endpackage : aspt_pkg

// >>> core/aspt_baud_gen.sv
// baud clock source: internal divider or synchronised external clock
`timescale 1ns/1ps
module aspt_baud_gen (
  input  logic       core_clk,
  input  logic       nrst,
  input  logic       useInternal, // 1: divider, 0: pin
  input  logic [7:0] divisor,     // core cycles per tick minus one
  input  logic       extClkPin,   // external baud clock pin
  output logic       tick         // one-cycle baud enable
);
  logic [7:0] divCnt;   // internal divider count
  logic [2:0] extSync;  // two sync stages plus edge history
  // ----------------------------------------------------------------
  // pin synchroniser and divider
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      extSync <= 3'h0;
      divCnt  <= 8'h00;
      tick    <= 1'b0;
    end else begin
      extSync <= {extSync[1:0], extClkPin};
      if (useInternal) begin
        // count down and pulse on wrap
        tick   <= (divCnt == 8'h00);
        divCnt <= (divCnt == 8'h00) ? divisor : divCnt - 8'h01;
      end else begin
        // rising edge of the synchronised pin
        tick   <= extSync[1] & ~extSync[2];
        divCnt <= 8'h00;
      end
    end
  end
endmodule : aspt_baud_gen

// >>> core/aspt_tx.sv
// transmitter: frames a character and shifts it out lsb first
`timescale 1ns/1ps
module aspt_tx #(
  parameter int BIT_TICKS = 16 // baud ticks per bit
) (
  input  logic              core_clk,
  input  logic              nrst,
  input  logic              tick,    // baud enable
  input  logic              txEn,    // transmit_enable_bit
  input  logic              load,    // write to shift register
  input  logic [7:0]        data,    // character
  input  logic              len8,    // eight character bits
  input  logic              twoStop, // two stop bits
  input  aspt_pkg::aspt_par_t pm,    // parity mode
  output logic              txd,     // serial out
  output logic              busy,    // frame in progress
  output logic              done     // one-cycle completion
);
  logic [11:0] frame;  // remaining bits, lsb is on the line
  logic [3:0]  bitsLeft; // bits still to send
  logic [7:0]  tickCnt;  // ticks within current bit
  logic [11:0] next_frame; // frame built at load
  logic [3:0]  next_len;   // its length in bits
  // ----------------------------------------------------------------
  // frame builder
  // ----------------------------------------------------------------
  always_comb begin
    int pos;
    pos = len8 ? 9 : 8;
    next_frame = 12'hFFF;                 // stop bits idle high
    next_frame[0] = 1'b0;                 // start bit
    for (int i = 0; i < 8; i++)
      if (i < pos - 1) next_frame[i + 1] = data[i];
    if (pm != aspt_pkg::PAR_NONE) begin   // RULE6
      next_frame[pos] = aspt_pkg::par_bit(data, len8, pm); // RULE1 RULE3 RULE5
      pos = pos + 1;
    end
    pos = pos + (twoStop ? 2 : 1);        // RULE8 RULE23
    next_len = 4'(pos);
  end
  // ----------------------------------------------------------------
  // shifter
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin                      // RULE12
      frame <= 12'hFFF;
      bitsLeft <= 4'h0;
      tickCnt <= 8'h00;
      txd <= 1'b1;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (!txEn) begin                    // RULE11
        busy <= 1'b0;
        txd <= 1'b1;                      // RULE25
      end else if (!busy) begin
        txd <= 1'b1;                      // RULE10
        if (load) begin                   // RULE7
          frame <= next_frame;
          bitsLeft <= next_len;
          tickCnt <= 8'h00;
          txd <= next_frame[0];
          busy <= 1'b1;
        end
      end else if (tick) begin
        if (tickCnt == 8'(BIT_TICKS - 1)) begin // RULE26
          tickCnt <= 8'h00;
          frame <= {1'b1, frame[11:1]};
          bitsLeft <= bitsLeft - 4'h1;
          txd <= frame[1];
          if (bitsLeft == 4'h1) begin     // RULE9
            busy <= 1'b0;
            done <= 1'b1;
            txd <= 1'b1;
          end
        end else begin
          tickCnt <= tickCnt + 8'h01;
        end
      end
    end
  end
endmodule : aspt_tx

// >>> core/aspt_top.sv
// async serial parity transceiver: registers, receiver, transmitter
// Notes on behaviour
// (RULE1) even parity: sent ones total even
// (RULE2) even parity: odd received total is error
// (RULE3) odd parity: sent ones total odd
// (RULE4) odd parity: even received total is error
// (RULE5) zero parity: send zero, never check
// (RULE6) no parity: no bit, no error
// (RULE7) write starts transmission while enabled
// (RULE8) start, parity, stop bits added automatically
// (RULE9) empty shift register raises transmit done
// (RULE10) without new write transmitter stays idle
// (RULE11) clearing transmit enable aborts at once
// (RULE12) after reset empty, no done pulse
// (RULE13) software avoids mode rewrite during transmit
// (RULE14) receive enable starts sampling serial input
// (RULE15) low after m ticks confirms start bit; code checks after HALF_M ticks, half a bit
// (RULE16) frame end loads buffer, raises receive done
// (RULE17) errored frame buffered; done unless suppressed
// (RULE18) clearing receive enable stops, changes nothing
// (RULE19) parity, framing, overrun flagged with irq
// (RULE20) missing stop bit is framing error
// (RULE21) unread buffer at frame end is overrun
// (RULE22) flags clear on buffer read or frame
// (RULE23) frame is start, 7/8, parity, 1/2 stop
// (RULE24) overrun clears other flags unless recurring
// (RULE25) serial output idles high
// (RULE26) lsb first, one baud period per bit
`timescale 1ns/1ps
module aspt_top #(
  parameter int HALF_M = 8 // baud ticks to the start check, half a bit
) (
  input  logic       core_clk,
  input  logic       nrst,
  input  logic [2:0] addr,           // register address
  input  logic [7:0] wrData,         // write data
  input  logic       wrStb,          // write strobe
  input  logic       rdStb,          // read strobe
  output logic [7:0] rdData,         // read data, cycle after strobe
  input  logic       rxdPin,         // serial in
  input  logic       extBaudPin,     // external baud clock
  output logic       txdPin,         // serial out
  output logic       transmit_done_irq,  // pulse
  output logic       receive_done_irq,   // pulse
  output logic       receive_error_irq   // pulse
);
  localparam int BIT_TICKS = 2 * HALF_M; // ticks per bit
  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [7:0] modeReg;     // async_mode_register
  logic [7:0] baudReg;     // baud_generator_control
  logic [2:0] status;      // async_error_status
  logic [7:0] rxBuf;       // receive_buffer
  logic       bufFull;     // unread character in buffer
  logic [1:0] rxSync;      // serial in synchroniser
  logic       rxPrev;      // previous synchronised level
  logic       baudTick;    // baud enable
  logic       txBusy;      // frame leaving
  logic       txDone;      // transmitter finished frame
  logic       txLine;      // transmitter serial level
  logic [7:0] rxShift;     // character being assembled
  logic [3:0] bitIdx;      // character bit position
  logic [7:0] tickCnt;     // divide-by-m counter
  logic       rxParity;    // received parity bit
  logic       frameEnd;    // stop bit sampled this cycle
  logic [2:0] next_flags;  // error flags of finishing frame
  logic       rxLevel;     // synchronised serial in
  logic       rdBuf;       // software reads the buffer
  logic       txOn;        // transmit enable
  logic       rxOn;        // receive enable
  logic       len8;        // eight character bits
  aspt_pkg::aspt_par_t pm; // parity mode
  // receiver states
  typedef enum logic [4:0] {
    RX_IDLE  = 5'h01,
    RX_START = 5'h02,
    RX_DATA  = 5'h04,
    RX_PAR   = 5'h08,
    RX_STOP  = 5'h10
  } aspt_rx_t;
  aspt_rx_t rxState;       // receiver state
  // ----------------------------------------------------------------
  // field decode
  // ----------------------------------------------------------------
  assign txOn    = modeReg[aspt_pkg::MODE_TX_EN];
  assign rxOn    = modeReg[aspt_pkg::MODE_RX_EN];
  assign len8    = modeReg[aspt_pkg::MODE_CL];
  assign pm      = aspt_pkg::aspt_par_t'(
                     modeReg[aspt_pkg::MODE_PS1:aspt_pkg::MODE_PS0]);
  assign rxLevel = rxSync[1];
  assign rdBuf   = rdStb && (addr == aspt_pkg::OFF_RXBUF);
  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  // mode and baud control, written by software only
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      modeReg <= aspt_pkg::MODE_RST;
      baudReg <= aspt_pkg::BAUD_RST;
    end else if (wrStb) begin
      if (addr == aspt_pkg::OFF_MODE) modeReg <= wrData;
      if (addr == aspt_pkg::OFF_BAUD) baudReg <= wrData;
    end
  end
  // ----------------------------------------------------------------
  // register reads
  // ----------------------------------------------------------------
  // data stand one cycle after the strobe, zero otherwise
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rdData <= 8'h00;
    end else if (rdStb) begin
      case (addr)
        aspt_pkg::OFF_MODE:   rdData <= modeReg;
        aspt_pkg::OFF_STATUS: rdData <= {5'h00, status};
        aspt_pkg::OFF_RXBUF:  rdData <= rxBuf;
        aspt_pkg::OFF_BAUD:   rdData <= baudReg;
        default:              rdData <= 8'h00; // unmapped and OFF_TXREG
      endcase
    end else begin
      rdData <= 8'h00;
    end
  end
  // ----------------------------------------------------------------
  // baud source and transmitter
  // ----------------------------------------------------------------
  aspt_baud_gen u_baud (
    .core_clk    (core_clk),
    .nrst        (nrst),
    .useInternal (modeReg[aspt_pkg::MODE_SCK]),
    .divisor     (baudReg),
    .extClkPin   (extBaudPin),
    .tick        (baudTick)
  );
  aspt_tx #(
    .BIT_TICKS (BIT_TICKS)
  ) u_tx (
    .core_clk (core_clk),
    .nrst     (nrst),
    .tick     (baudTick),
    .txEn     (txOn),
    .load     (wrStb && (addr == aspt_pkg::OFF_TXREG)), // RULE7
    .data     (wrData),
    .len8     (len8),
    .twoStop  (modeReg[aspt_pkg::MODE_SL]),
    .pm       (pm),
    .txd      (txLine),
    .busy     (txBusy),
    .done     (txDone)
  );
  // output flops for serial out and transmit completion
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      txdPin            <= 1'b1;            // RULE25
      transmit_done_irq <= 1'b0;            // RULE12
    end else begin
      txdPin            <= txLine;
      transmit_done_irq <= txDone;          // RULE9
    end
  end
  // ----------------------------------------------------------------
  // serial in synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rxSync <= 2'h3;
      rxPrev <= 1'b1;
    end else begin
      rxSync <= {rxSync[0], rxdPin};
      rxPrev <= rxLevel;
    end
  end
  // ----------------------------------------------------------------
  // error flags of the finishing frame
  // ----------------------------------------------------------------
  always_comb begin
    next_flags = 3'h0;
    next_flags[aspt_pkg::ST_FE]  = !rxLevel;          // RULE20
    next_flags[aspt_pkg::ST_OVR] = bufFull && !rdBuf; // RULE21
    if (pm == aspt_pkg::PAR_EVEN || pm == aspt_pkg::PAR_ODD)
      next_flags[aspt_pkg::ST_PE] = rxParity !=
        aspt_pkg::par_bit(rxShift, len8, pm);         // RULE2 RULE4
  end
  assign frameEnd = rxOn && baudTick && (rxState == RX_STOP) &&
                    (tickCnt == 8'(BIT_TICKS - 1));
  // ----------------------------------------------------------------
  // receiver sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rxState  <= RX_IDLE;
      tickCnt  <= 8'h00;
      bitIdx   <= 4'h0;
      rxShift  <= 8'h00;
      rxParity <= 1'b0;
    end else if (!rxOn) begin
      rxState <= RX_IDLE;                  // RULE18
      tickCnt <= 8'h00;
    end else begin
      case (rxState)
        RX_IDLE: begin                     // RULE14
          tickCnt <= 8'h00;
          if (rxPrev && !rxLevel) rxState <= RX_START; // RULE15
        end
        RX_START: begin
          if (baudTick) begin
            if (tickCnt == 8'(HALF_M - 1)) begin
              tickCnt <= 8'h00;            // RULE15
              bitIdx  <= 4'h0;
              rxShift <= 8'h00;
              rxState <= rxLevel ? RX_IDLE : RX_DATA;
            end else begin
              tickCnt <= tickCnt + 8'h01;
            end
          end
        end
        RX_DATA: begin
          if (baudTick) begin
            if (tickCnt == 8'(BIT_TICKS - 1)) begin
              tickCnt <= 8'h00;
              rxShift[bitIdx[2:0]] <= rxLevel; // RULE26
              bitIdx <= bitIdx + 4'h1;
              if (bitIdx == (len8 ? 4'h7 : 4'h6))  // RULE23
                rxState <= (pm == aspt_pkg::PAR_NONE) ?
                           RX_STOP : RX_PAR; // RULE6
            end else begin
              tickCnt <= tickCnt + 8'h01;
            end
          end
        end
        RX_PAR: begin
          if (baudTick) begin
            if (tickCnt == 8'(BIT_TICKS - 1)) begin
              tickCnt  <= 8'h00;
              rxParity <= rxLevel;
              rxState  <= RX_STOP;
            end else begin
              tickCnt <= tickCnt + 8'h01;
            end
          end
        end
        RX_STOP: begin
          if (baudTick) begin
            if (frameEnd) begin
              tickCnt <= 8'h00;
              rxState <= RX_IDLE;          // one stop bit checked
            end else begin
              tickCnt <= tickCnt + 8'h01;
            end
          end
        end
        default: rxState <= RX_IDLE;
      endcase
    end
  end
  // ----------------------------------------------------------------
  // receive buffer, status and receive irqs
  // ----------------------------------------------------------------
  // a frame ending in the read cycle wins over the read clear
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rxBuf             <= 8'h00;
      bufFull           <= 1'b0;
      status            <= 3'h0;
      receive_done_irq  <= 1'b0;
      receive_error_irq <= 1'b0;
    end else begin
      receive_done_irq  <= 1'b0;
      receive_error_irq <= 1'b0;
      if (frameEnd) begin
        rxBuf   <= rxShift;                // RULE16 RULE17
        bufFull <= 1'b1;
        status  <= next_flags;             // RULE22 RULE24
        receive_error_irq <= |next_flags;  // RULE19
        receive_done_irq  <= !(|next_flags) ||
                             !modeReg[aspt_pkg::MODE_ESUP]; // RULE17
      end else if (rdBuf) begin
        bufFull <= 1'b0;
        status  <= 3'h0;                   // RULE22
      end
    end
  end
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_err_irq_flag: assert property ( // RULE19
    @(posedge core_clk) disable iff (!nrst)
    receive_error_irq |-> status != 3'h0)
    else $error("error irq without a flag");
  a_done_suppress: assert property ( // RULE17
    @(posedge core_clk) disable iff (!nrst)
    receive_error_irq && receive_done_irq
      |-> !$past(modeReg[aspt_pkg::MODE_ESUP]))
    else $error("done irq on error while suppressed");
  a_no_par_error: assert property ( // RULE5
    @(posedge core_clk) disable iff (!nrst)
    $rose(bufFull) && $past(pm) inside {aspt_pkg::PAR_NONE,
                                         aspt_pkg::PAR_ZERO}
      |-> !status[aspt_pkg::ST_PE])
    else $error("parity error in unchecked mode");
  a_read_clears: assert property ( // RULE22
    @(posedge core_clk) disable iff (!nrst)
    rdBuf && !frameEnd |=> status == 3'h0 && !bufFull)
    else $error("buffer read left flags set");
  a_overrun_set: assert property ( // RULE21
    @(posedge core_clk) disable iff (!nrst)
    frameEnd && bufFull && !rdBuf
      |=> status[aspt_pkg::ST_OVR] && receive_error_irq)
    else $error("overrun not flagged");
  a_rx_abort: assert property ( // RULE18
    @(posedge core_clk) disable iff (!nrst)
    !rxOn |=> rxState == RX_IDLE && !receive_done_irq
             && $stable(rxBuf) && $stable(bufFull))
    else $error("receiver ran while disabled");
  a_tx_idle_high: assert property ( // RULE25
    @(posedge core_clk) disable iff (!nrst)
    !txOn ##1 !txOn |=> txdPin)
    else $error("serial out low while disabled");
  a_tx_start: assert property ( // RULE7
    @(posedge core_clk) disable iff (!nrst)
    wrStb && addr == aspt_pkg::OFF_TXREG && txOn && !txBusy
      |=> txBusy ##1 !txdPin)
    else $error("write did not start a frame");
  a_tx_done: assert property ( // RULE9
    @(posedge core_clk) disable iff (!nrst)
    $fell(txBusy) && txOn |=> transmit_done_irq && txdPin)
    else $error("frame end without done pulse");
endmodule : aspt_top

// >>> dv/aspt_remote.sv
// remote serial partner: drives frames in, samples frames out
`timescale 1ns/1ps
module aspt_remote #(
  parameter int BITC = 4 // core cycles per bit
) (
  input  logic core_clk, // shared time base
  input  logic txdLine,  // line from the device
  output logic rxdLine   // line into the device
);
  logic [11:0] seen; // mid-bit samples, start bit at bit 0
  initial rxdLine = 1'b1; // idle mark level
  // capture twelve bit periods after each falling edge that comes while no capture runs
  always begin
    @(negedge txdLine);
    repeat (BITC / 2) @(posedge core_clk);
    for (int i = 0; i < 12; i++) begin
      seen[i] = txdLine;
      repeat (BITC) @(posedge core_clk);
    end
  end
  // send n bits lsb first, one bit period each, then idle high
  task automatic send(input logic [11:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      rxdLine <= bits[i];
      repeat (BITC) @(posedge core_clk);
    end
    rxdLine <= 1'b1;
  endtask : send
endmodule : aspt_remote

// >>> dv/aspt_top_tb_top.sv
// self-checking bench for the async serial parity transceiver
`timescale 1ns/1ps
module aspt_top_tb_top;
  localparam int BITC = 4; // two half bits, one tick a cycle
  logic        core_clk, nrst, wrStb, rdStb, rxdPin, txdPin;
  logic [2:0]  addr;
  logic [7:0]  wrData, rdData, rv, m, c;
  logic        txIrq, rxIrq, erIrq;
  logic [11:0] txN = '0, rxN = '0, erN = '0, lowN = '0, l0;
  logic [11:0] eTx = '0, eRx = '0, eEr = '0, f;
  int          errCount = 0, checksDone = 0, cyc = 0, n;
  // rows: mode, character, flip parity, expected status
  logic [19:0] rows [8] = '{20'hF9070, 20'hF9A5C, 20'hE9350,
    20'hE935C, 20'hD9FF8, 20'hC95A0, 20'hF5D30, 20'hE5010};
  aspt_top #(.HALF_M(2)) aspt_top_inst (.core_clk(core_clk),
    .nrst(nrst), .addr(addr), .wrData(wrData), .wrStb(wrStb),
    .rdStb(rdStb), .rdData(rdData), .rxdPin(rxdPin),
    .extBaudPin(1'b0), .txdPin(txdPin), .transmit_done_irq(txIrq),
    .receive_done_irq(rxIrq), .receive_error_irq(erIrq));
  aspt_remote #(.BITC(BITC)) aspt_remote_inst (.core_clk(core_clk),
    .txdLine(txdPin), .rxdLine(rxdPin));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // pulse and low-line counters, sampled away from the edge
  always @(negedge core_clk) begin
    if (txIrq === 1'b1) txN++;
    if (rxIrq === 1'b1) rxN++;
    if (erIrq === 1'b1) erN++;
    if (txdPin !== 1'b1) lowN++;
  end
  // hang guard
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 4000) begin
      errCount++;
      tally_and_finish();
    end
  end
  // expected frame: start, char lsb first, parity, stops, idle
  function automatic logic [11:0] frm(input logic [7:0] md, ch,
                                      output int len);
    logic [11:0] b;
    b = '1;
    b[0] = 1'b0;
    len = md[3] ? 9 : 8;
    for (int i = 0; i < len - 1; i++) begin
      b[i+1] = ch[i];
    end
    if (md[5:4] != 2'h0) begin
      b[len] = md[5] & (^ch[6:0] ^ (md[3] & ch[7]) ^ ~md[4]);
      len++;
    end
    len += md[2] ? 2 : 1;
    return b;
  endfunction : frm
  task automatic chk(input string nm, input logic [11:0] got, exp);
    checksDone++;
    if (got !== exp) begin
      errCount++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    addr   <= a;
    wrData <= d;
    wrStb  <= 1'b1;
    @(posedge core_clk);
    wrStb  <= 1'b0;
    @(posedge core_clk);
  endtask : wr
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    addr  <= a;
    rdStb <= 1'b1;
    @(posedge core_clk);
    rdStb <= 1'b0;
    @(posedge core_clk);
    d = rdData; // data of the strobe cycle, before this edge updates
  endtask : rd
  task automatic waitTx;
    for (int i = 0; i < 200 && txN != eTx; i++) begin
      @(posedge core_clk);
    end
    repeat (3 * BITC) @(posedge core_clk);
  endtask : waitTx
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checksDone, errCount);
    if (errCount == 0 && checksDone > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    nrst = 1'b0;
    wrStb = 1'b0;
    rdStb = 1'b0;
    addr = 3'h0;
    wrData = 8'h00;
    repeat (6) @(posedge core_clk);
    nrst <= 1'b1;
    foreach (rows[r]) begin
      m = rows[r][19:12];
      c = rows[r][11:4];
      wr(3'h0, m);
      wr(3'h2, c);
      eTx++;
      waitTx();
      f = frm(m, c, n);
      chk("frame", aspt_remote_inst.seen, f);
      chk("tx done", txN, eTx);
      f[m[3] ? 9 : 8] ^= rows[r][3];
      aspt_remote_inst.send(f, n);
      repeat (4) @(posedge core_clk);
      eRx++;
      eEr += (rows[r][2:0] != 3'h0);
      rd(3'h1, rv);
      chk("status", rv, rows[r][2:0]);
      rd(3'h3, rv);
      chk("buffer", rv, c & (m[3] ? 8'hFF : 8'h7F));
      chk("rx done", rxN, eRx);
      chk("rx err", erN, eEr);
    end
    wr(3'h0, 8'hCB);
    f = frm(8'hCB, 8'h3C, n);
    f[9] = 1'b0;
    aspt_remote_inst.send(f, n);
    repeat (4) @(posedge core_clk);
    eEr++;
    rd(3'h1, rv);
    chk("framing", rv, 8'h02);
    chk("suppressed", rxN, eRx);
    f = frm(8'hCB, 8'hC3, n);
    aspt_remote_inst.send(f, n);
    repeat (4) @(posedge core_clk);
    eEr++;
    rd(3'h1, rv);
    chk("overrun", rv, 8'h01);
    rd(3'h3, rv);
    chk("buffer", rv, 8'hC3);
    rd(3'h1, rv);
    chk("cleared", rv, 8'h00);
    chk("rx err", erN, eEr);
    f = frm(8'hCB, 8'h55, n);
    fork
      aspt_remote_inst.send(f, n);
      begin
        repeat (3 * BITC) @(posedge core_clk);
        wr(3'h0, 8'h8B);
      end
    join
    repeat (4) @(posedge core_clk);
    rd(3'h3, rv);
    chk("kept buffer", rv, 8'hC3);
    chk("no rx irq", rxN + erN, eRx + eEr);
    wr(3'h2, 8'h00);
    repeat (2 * BITC) @(posedge core_clk);
    wr(3'h0, 8'h0B);
    // let the abort pass both the transmit and the output flop
    repeat (2) @(posedge core_clk);
    chk("abort line", txdPin, 1'b1);
    l0 = lowN;
    wr(3'h2, 8'h00);
    repeat (60) @(posedge core_clk);
    chk("stays idle", lowN, l0);
    chk("no done", txN, eTx);
    rd(3'h7, rv);
    chk("unmapped", rv, 8'h00);
    nrst <= 1'b0;
    repeat (6) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (20) @(posedge core_clk);
    rd(3'h0, rv);
    chk("mode reset", rv, 8'h00);
    chk("no reset done", txN, eTx);
    wr(3'h0, 8'h89);
    wr(3'h2, 8'h81);
    eTx++;
    waitTx();
    chk("after reset", aspt_remote_inst.seen, frm(8'h89, 8'h81, n));
    tally_and_finish();
  end
endmodule : aspt_top_tb_top
